// *** rtl/brake_dir_map.svh ***
// register offsets, reset values and timing figures of the brake and direction block
`ifndef BRAKE_DIR_MAP_SVH
`define BRAKE_DIR_MAP_SVH
`define REG_BRAKE_RELEASE_DELAY 12'h50e
`define REG_BRAKE_APPLY_DELAY   12'h510
`define REG_ROTATION_DIRECTION  12'h618
`define RST_DELAY_MS            16'h0000
`define RST_DIRECTION           16'h0000
`define DELAY_MAX_MS            16'h03e8
`define TICK_PERIOD_NS          1000000
`define CLK_PERIOD_NS           8
`define TICK_CYCLES             (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// *** rtl/brake_dir_pkg.sv ***
// types of the brake sequencing and direction block
package brake_dir_pkg;
    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_RELEASE = 4'b0010,
        ST_RUN     = 4'b0100,
        ST_APPLY   = 4'b1000
    } brake_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        brake_state_t state;
        logic [15:0]  rel_delay;
        logic [15:0]  app_delay;
        logic [15:0]  dir_cfg;
        logic         dir_act;
        logic         dir_loaded;
        logic         cfg_valid;
        logic [16:0]  tick_cnt;
        logic         tick;
        logic [15:0]  ms_cnt;
        logic         brake_release_out;
        logic         stage_on;
        logic         motion_en;
        logic [15:0]  rdata;
        logic signed [31:0] abs_pos;
        logic signed [31:0] act_pos;
        logic signed [31:0] speed_cmd;
    } brake_dir_state_t;
endpackage

// *** rtl/brake_dir_ctrl.sv ***
// holding brake sequencing and rotation direction selection
`timescale 1ns/1ps
`include "brake_dir_map.svh"
// Behaviour
// R1: brake release output goes high once output stage is on with holding torque
// R2: release output is 1 for released or releasing, 0 for applied or applying
// R3: after enable, motion response waits release delay after output goes high
// R4: release delay is 16-bit read-write milliseconds, 0 to 1000, default 0
// R5: on enable withdrawal the release output drops low at once
// R6: output stage stays energised for apply delay after enable withdrawal
// R7: apply delay is 16-bit read-write milliseconds, 0 to 1000, default 0
// R8: after power-up reset the brake is unpowered and held applied
// R9: direction change takes effect only after the next power cycle
// R10: default direction gives clockwise rotation for positive speed
// R11: installer wires limit switches to match direction, rewiring after changes
// R12: reversed direction negates absolute and actual position values
// R13: delays count down once per millisecond tick; zero means no delay
module brake_dir_ctrl
    import brake_dir_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire reg_req_t           reg_req,
    output logic [15:0]             reg_rdata,
    input  wire logic               enable,
    input  wire logic signed [31:0] speed_in,
    input  wire logic signed [31:0] enc_abs_pos,
    input  wire logic signed [31:0] eval_act_pos,
    output logic                    brake_release_out,
    output logic                    stage_on,
    output logic                    motion_en,
    output logic signed [31:0]      speed_cmd,
    output logic signed [31:0]      abs_pos_out,
    output logic signed [31:0]      act_pos_out
);

    brake_dir_state_t s_r;
    brake_dir_state_t s_nxt;

    // ----------------------------------------------------------------
    // millisecond tick, register file, brake sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.tick      = 1'b0;
        s_nxt.cfg_valid = 1'b1;
        if (s_r.tick_cnt == 17'(TICK_CYCLES - 1))
        begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick     = 1'b1;                                  // [R13]
        end
        else
        begin
            s_nxt.tick_cnt = s_r.tick_cnt + 17'h00001;
        end

        // direction is latched once after every reset, power-up included [R9]
        if (!s_r.dir_loaded)
        begin
            s_nxt.dir_act    = s_r.dir_cfg[0];
            s_nxt.dir_loaded = 1'b1;
        end

        // values above the range are clamped rather than rejected [R4] [R7]
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                `REG_BRAKE_RELEASE_DELAY: s_nxt.rel_delay = (reg_req.wdata > `DELAY_MAX_MS) ?
                                                            `DELAY_MAX_MS : reg_req.wdata;   // [R4]
                `REG_BRAKE_APPLY_DELAY:   s_nxt.app_delay = (reg_req.wdata > `DELAY_MAX_MS) ?
                                                            `DELAY_MAX_MS : reg_req.wdata;   // [R7]
                `REG_ROTATION_DIRECTION:  s_nxt.dir_cfg   = reg_req.wdata;                   // [R9]
                default: ;
            endcase
        end
        case (reg_req.addr)
            `REG_BRAKE_RELEASE_DELAY: s_nxt.rdata = s_r.rel_delay;
            `REG_BRAKE_APPLY_DELAY:   s_nxt.rdata = s_r.app_delay;
            `REG_ROTATION_DIRECTION:  s_nxt.rdata = s_r.dir_cfg;
            default:                  s_nxt.rdata = 16'h0000;
        endcase

        case (s_r.state)
            ST_OFF:
            begin
                s_nxt.brake_release_out = 1'b0;
                s_nxt.stage_on          = 1'b0;
                s_nxt.motion_en         = 1'b0;
                if (enable)
                begin
                    s_nxt.stage_on          = 1'b1;
                    s_nxt.brake_release_out = 1'b1;                 // [R1] [R2]
                    s_nxt.ms_cnt            = s_r.rel_delay;
                    s_nxt.state             = (s_r.rel_delay == 16'h0000) ? ST_RUN : ST_RELEASE;
                    s_nxt.motion_en         = (s_r.rel_delay == 16'h0000);  // [R13]
                end
            end
            ST_RELEASE, ST_RUN:
            begin
                if (!enable)
                begin
                    s_nxt.brake_release_out = 1'b0;                 // [R5] [R2]
                    s_nxt.motion_en         = 1'b0;
                    s_nxt.ms_cnt            = s_r.app_delay;
                    s_nxt.state             = (s_r.app_delay == 16'h0000) ? ST_OFF : ST_APPLY;
                    s_nxt.stage_on          = (s_r.app_delay != 16'h0000);   // [R6] [R13]
                end
                else if (s_r.state == ST_RELEASE && s_r.tick)
                begin
                    s_nxt.ms_cnt = s_r.ms_cnt - 16'h0001;
                    if (s_r.ms_cnt == 16'h0001)
                    begin
                        s_nxt.state     = ST_RUN;
                        s_nxt.motion_en = 1'b1;                     // [R3]
                    end
                end
            end
            ST_APPLY:
            begin
                // motor keeps torque while the brake closes [R6]
                if (s_r.tick)
                begin
                    s_nxt.ms_cnt = s_r.ms_cnt - 16'h0001;
                    if (s_r.ms_cnt == 16'h0001)
                    begin
                        s_nxt.state    = ST_OFF;
                        s_nxt.stage_on = 1'b0;
                    end
                end
            end
            default:
            begin
                s_nxt.state             = ST_OFF;
                s_nxt.brake_release_out = 1'b0;
                s_nxt.stage_on          = 1'b0;
                s_nxt.motion_en         = 1'b0;
            end
        endcase

        // direction 0 passes values unchanged: positive speed turns clockwise [R10] [R12]
        s_nxt.speed_cmd = s_r.dir_act ? -speed_in     : speed_in;
        s_nxt.abs_pos   = s_r.dir_act ? -enc_abs_pos  : enc_abs_pos;    // [R12]
        s_nxt.act_pos   = s_r.dir_act ? -eval_act_pos : eval_act_pos;   // [R12]
        if (!s_r.motion_en)
        begin
            s_nxt.speed_cmd = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r           <= '0;                                    // [R8]
            s_r.state     <= ST_OFF;
            // settings are persistent, so a later reset keeps them and the
            // direction latch then picks up a pending change [R9]
            if (s_r.cfg_valid == 1'b1)
            begin
                s_r.cfg_valid <= 1'b1;
                s_r.rel_delay <= s_r.rel_delay;
                s_r.app_delay <= s_r.app_delay;
                s_r.dir_cfg   <= s_r.dir_cfg;
            end
            else
            begin
                s_r.rel_delay <= `RST_DELAY_MS;                     // [R4] [R7]
                s_r.app_delay <= `RST_DELAY_MS;
                s_r.dir_cfg   <= `RST_DIRECTION;
            end
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata         = s_r.rdata;
    assign brake_release_out = s_r.brake_release_out;
    assign stage_on          = s_r.stage_on;
    assign motion_en         = s_r.motion_en;
    assign speed_cmd         = s_r.speed_cmd;
    assign abs_pos_out       = s_r.abs_pos;
    assign act_pos_out       = s_r.act_pos;
endmodule

// *** dv/brake_dir_props.sv ***
// port assertions of the brake and direction block
`timescale 1ns/1ps
`include "brake_dir_map.svh"
module brake_dir_props
    import brake_dir_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire reg_req_t           reg_req,
    input wire logic [15:0]        reg_rdata,
    input wire logic               enable,
    input wire logic signed [31:0] enc_abs_pos,
    input wire logic               brake_release_out,
    input wire logic               stage_on,
    input wire logic               motion_en,
    input wire logic signed [31:0] abs_pos_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    rise_release_a: assert property ($rose(enable) && !stage_on |=> brake_release_out && stage_on)
        else $error("release late");
    stage_held_a: assert property (brake_release_out |-> stage_on)
        else $error("release without stage");
    drop_brake_a: assert property ($fell(enable) |=> !brake_release_out && !motion_en)
        else $error("brake not applied");
    motion_gate_a: assert property (motion_en |-> brake_release_out)
        else $error("motion with brake applied");
    stage_off_a: assert property ($fell(stage_on) |-> !brake_release_out && !motion_en)
        else $error("stage off while released");
    reset_off_a: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> !brake_release_out && !stage_on)
        else $error("brake powered in reset");
    pos_map_a: assert property (!$past(rst) |-> (abs_pos_out == $past(enc_abs_pos) || abs_pos_out == -$past(enc_abs_pos)))
        else $error("position mapping");
    unmapped_a: assert property (!(reg_req.addr inside {`REG_BRAKE_RELEASE_DELAY, `REG_BRAKE_APPLY_DELAY,
        `REG_ROTATION_DIRECTION}) |=> reg_rdata == 16'h0000)
        else $error("unmapped read");
    delay_clamp_a: assert property (reg_req.wr && reg_req.addr == `REG_BRAKE_RELEASE_DELAY && reg_req.wdata >
        `DELAY_MAX_MS ##1 reg_req.addr == `REG_BRAKE_RELEASE_DELAY |=> reg_rdata == `DELAY_MAX_MS)
        else $error("delay not clamped");
    cover property ($rose(motion_en));
    cover property ($fell(stage_on));
    cover property ($rose(brake_release_out));
endmodule
bind brake_dir_ctrl brake_dir_props u_brake_dir_props (.*);

// *** dv/brake_amp_model.sv ***
// behavioural holding brake amplifier fed by the release output
`timescale 1ns/1ps
module brake_amp_model
(
    input wire logic ref_clk,
    input wire logic brake_release_out,
    output logic     brake_open
);
    // coil lag folded into one clock; brake unpowered from power-up
    initial brake_open = 1'b0;
    always @(posedge ref_clk) brake_open <= brake_release_out;
endmodule

// *** dv/holding_brake_timing_and_direction_test.sv ***
// self-checking bench of the brake and direction block
`timescale 1ns/1ps
`include "brake_dir_map.svh"
module holding_brake_timing_and_direction_test;
    import brake_dir_pkg::*;
    localparam int T = 10;
    logic               ref_clk = 0, rst = 1, enable = 0;
    logic               brake_release_out, stage_on, motion_en, brake_open;
    reg_req_t           reg_req = '0;
    logic [15:0]        reg_rdata;
    logic signed [31:0] speed_in = 0, enc_abs_pos = 0, eval_act_pos = 0, speed_cmd, abs_pos_out, act_pos_out;
    int                 mismatches = 0, n_tests = 0, dir = 0, n, rel, app;
    initial forever #4 ref_clk = ~ref_clk;
    brake_dir_ctrl #(.TICK_CYCLES(T)) u_brake_dir_ctrl (.*);
    brake_amp_model u_brake_amp_model (.*);
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_req = '{a, 1'b1, d};
        step(1);
        reg_req.wr = 0;
        step(1);
    endtask
    task automatic rd(input logic [11:0] a, input int e, input string s);
        reg_req.addr = a;
        step(2);
        chk(s, e, reg_rdata);
    endtask
    task automatic run(input int r, input int a);
        enable = 1;
        step(1);
        chk("release", 3, {brake_release_out, stage_on});
        for (n = 0; n < 2 * T * (r + 1) && !motion_en; n++) step(1);
        chk("rel_wait", 1, n >= (r - 1) * T && n <= (r + 1) * T && motion_en);
        speed_in = $urandom;
        enc_abs_pos = $urandom;
        eval_act_pos = $urandom;
        step(2);
        chk("speed", dir ? -speed_in : speed_in, speed_cmd);
        chk("abs_pos", dir ? -enc_abs_pos : enc_abs_pos, abs_pos_out);
        chk("act_pos", dir ? -eval_act_pos : eval_act_pos, act_pos_out);
        enable = 0;
        step(1);
        chk("drop", 0, {brake_release_out, motion_en});
        for (n = 0; n < 2 * T * (a + 1) && stage_on; n++) step(1);
        chk("app_wait", 1, n >= (a - 1) * T && n <= (a + 1) * T && !stage_on);
        // the amplifier follows the release output one clock later
        step(1);
        chk("brake", 0, brake_open);
    endtask
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        step(20000);
        mismatches++;
        final_report();
    end
    initial
    begin
        void'($urandom(32'h00167052));
        step(4);
        chk("rst_out", 0, {brake_release_out, stage_on});
        rst = 0;
        rd(`REG_BRAKE_RELEASE_DELAY, 0, "rel_rst");
        rd(`REG_BRAKE_APPLY_DELAY, 0, "app_rst");
        rd(`REG_ROTATION_DIRECTION, 0, "dir_rst");
        rd(12'h7ff, 0, "unmapped");
        wr(`REG_BRAKE_RELEASE_DELAY, 16'hffff);
        rd(`REG_BRAKE_RELEASE_DELAY, 1000, "rel_clamp");
        rel = $urandom_range(4, 1);
        app = $urandom_range(4, 1);
        wr(`REG_BRAKE_RELEASE_DELAY, rel[15:0]);
        wr(`REG_BRAKE_APPLY_DELAY, app[15:0]);
        rd(`REG_BRAKE_APPLY_DELAY, app, "app_rw");
        wr(`REG_ROTATION_DIRECTION, 16'h0001);
        run(rel, app);
        // a second reset stands in for the power cycle that adopts the new direction
        rst = 1;
        step(2);
        rst = 0;
        dir = 1; // positive speed now turns anticlockwise, so limit wiring swaps too
        wr(`REG_BRAKE_RELEASE_DELAY, 16'h0000);
        wr(`REG_BRAKE_APPLY_DELAY, 16'h0000);
        run(0, 0);
        final_report();
    end
endmodule
